/* hdl/smpg_top.sv */
// Purpose: sleep mode and core regulator power gating controller
// Assumes: all status inputs come from logic on aclk
// Notes: gating outputs follow the sleep state one cycle later

`timescale 1ns/100ps

module smpg_top
  import smpg_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NCOND = N_COND
)
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // cpu and debug
  input wire logic sleep_instr,
  input wire logic debug_break,
  output logic cpu_halt,
  // wake sources
  input wire logic irq_any,
  input wire logic irq_standby,
  input wire logic irq_pdown,
  input wire logic irq_two_wire_target,
  input wire logic irq_configurable_logic,
  // clock and supply status
  input wire logic low_freq_internal_osc_only,
  input wire logic bod_sampled_mode,
  input wire logic osc_ready,
  input wire logic reg_ready,
  // regulator
  output logic reg_low_current,
  output logic reg_full_perf,
  output logic leak_save,
  // peripheral and clock gating
  output logic [NCOND-1:0] cond_periph_run,
  output logic other_periph_run,
  output logic rtc_counter_run,
  output logic periodic_interrupt_timer_run,
  output logic main_clk_run,
  output logic configurable_logic_clk_run,
  output logic dead_time_timer_clk_run,
  output logic wdt_run,
  output logic bod_run,
  output logic event_routing_run,
  output logic bod_osc_run
);

  // ==========================================================
  // declarations
  localparam int KEEP_W = NCOND + 2;

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [31:0] wmask;
  logic [7:0] ctrl_q;
  logic [7:0] vreg_q;
  logic [KEEP_W-1:0] keep_q;
  logic [MODE_W-1:0] mode_sel;
  logic [PSEL_W-1:0] psel;
  logic hot_leak;
  logic sleep_arm;
  logic [MODE_W-1:0] depth_q;
  smpg_state_e state_q;
  smpg_state_e state_d;
  logic wake_req;
  logic wake_start;
  logic wake_done;
  logic in_idle;
  logic in_stby;
  logic in_pdn;
  logic awake;

  // ==========================================================
  // functions
  function automatic logic idx_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    idx_mapped = (idx <= (ADDR_W-2)'(IDX_STAT));
  endfunction

  function automatic logic [5:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = 6'(a[ADDR_W-1:2]);
  endfunction

  function automatic logic mode_valid(input logic [MODE_W-1:0] m);
    mode_valid = (m == MODE_IDLE) || (m == MODE_STANDBY) ||
                 (m == MODE_PDOWN);
  endfunction

  // ==========================================================
  // bus slave
  smpg_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  assign wr_ok = idx_mapped(wr_addr);
  assign rd_ok = idx_mapped(rd_addr);

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_mask
      assign wmask[8*b +: 8] = {8{wr_strb[b]}};
    end
  endgenerate

  // ==========================================================
  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      vreg_q <= VREG_RST;
      keep_q <= KEEP_RST;
    end
    else if (ce && wr_en && wr_ok)
    begin
      case (idx_of(wr_addr))
        IDX_CTRL: ctrl_q <= (ctrl_q & ~wmask[7:0]) |
                            (wr_data[7:0] & wmask[7:0] & 8'h0f);
        IDX_VREG: vreg_q <= (vreg_q & ~wmask[7:0]) |
                            (wr_data[7:0] & wmask[7:0] & 8'h17);
        IDX_KEEP: keep_q <= (keep_q & ~wmask[KEEP_W-1:0]) |
                            (wr_data[KEEP_W-1:0] & wmask[KEEP_W-1:0]);
        default: ;
      endcase
    end
  end

  assign sleep_arm = ctrl_q[CTRL_ARM_BIT];
  assign mode_sel = ctrl_q[CTRL_MODE_LSB +: MODE_W];
  assign psel = vreg_q[VREG_PSEL_LSB +: PSEL_W];
  assign hot_leak = vreg_q[VREG_HOT_BIT];

  always_comb
  begin
    rd_data = 32'h0;
    case (idx_of(rd_addr))
      IDX_CTRL: rd_data[7:0] = ctrl_q;
      IDX_VREG: rd_data[7:0] = vreg_q;
      IDX_KEEP: rd_data[KEEP_W-1:0] = keep_q;
      IDX_STAT:
      begin
        rd_data[STAT_STATE_LSB +: 2] = state_q;
        rd_data[STAT_MODE_LSB +: MODE_W] = depth_q;
        rd_data[STAT_LOWCUR_BIT] = reg_low_current;
        rd_data[STAT_FULL_BIT] = reg_full_perf;
      end
      default: rd_data = 32'h0;
    endcase
  end

  // ==========================================================
  // sleep state machine
  assign in_idle = (state_q == ST_SLEEP) && (depth_q == MODE_IDLE);
  assign in_stby = (state_q == ST_SLEEP) && (depth_q == MODE_STANDBY);
  assign in_pdn = (state_q == ST_SLEEP) && (depth_q == MODE_PDOWN);
  assign awake = !in_stby && !in_pdn;

  // the two-wire and logic wake paths are dropped while hot leakage
  // saving is on; software should have disabled them beforehand
  always_comb
  begin
    wake_req = debug_break;
    if (in_idle)
      wake_req = wake_req || irq_any;
    else if (in_stby)
      wake_req = wake_req || irq_standby || irq_two_wire_target ||
                 irq_configurable_logic;
    else if (in_pdn)
      wake_req = wake_req || irq_pdown ||
                 (!hot_leak && (irq_two_wire_target ||
                 irq_configurable_logic));
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE:
        // reserved codes never enter sleep
        if (sleep_instr && sleep_arm && mode_valid(mode_sel))
          state_d = ST_SLEEP;
      ST_SLEEP:
        if (wake_req)
          state_d = ST_WAKE;
      ST_WAKE:
        if (wake_done)
          state_d = ST_ACTIVE;
      default: state_d = ST_ACTIVE;
    endcase
  end

  assign wake_start = (state_q == ST_SLEEP) && wake_req;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_ACTIVE;
      depth_q <= MODE_IDLE;
    end
    else if (ce)
    begin
      state_q <= state_d;
      if (state_q == ST_ACTIVE && state_d == ST_SLEEP)
        depth_q <= mode_sel;
    end
  end

  // idle keeps the main source and regulator up, so only the count
  smpg_wake_timer #(
    .CYCLES(WAKE_CYCLES)
  ) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(wake_start),
    .need_osc(!in_idle && !(in_stby && keep_q[KEEP_MCLK_BIT])),
    .need_reg(reg_low_current),
    .osc_ready(osc_ready),
    .reg_ready(reg_ready),
    .done(wake_done)
  );

  // ==========================================================
  // regulator control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reg_full_perf <= 1'b1;
      reg_low_current <= 1'b0;
      leak_save <= 1'b0;
    end
    else if (ce)
    begin
      reg_full_perf <= (psel == PSEL_FULL) || awake;
      reg_low_current <= (psel == PSEL_AUTO) && !awake &&
                         low_freq_internal_osc_only;
      leak_save <= in_pdn && hot_leak;
    end
  end

  // ==========================================================
  // peripheral and clock gating
  generate
    for (genvar i = 0; i < NCOND; i++)
    begin : g_cond
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cond_periph_run[i] <= 1'b1;
        else if (ce)
          cond_periph_run[i] <= awake ||
            (in_stby && keep_q[KEEP_PERIPH_LSB + i]);
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_halt <= 1'b0;
      other_periph_run <= 1'b1;
      rtc_counter_run <= 1'b1;
      periodic_interrupt_timer_run <= 1'b1;
      main_clk_run <= 1'b1;
      configurable_logic_clk_run <= 1'b1;
      dead_time_timer_clk_run <= 1'b1;
      wdt_run <= 1'b1;
      bod_run <= 1'b1;
      event_routing_run <= 1'b1;
      bod_osc_run <= 1'b1;
    end
    else if (ce)
    begin
      cpu_halt <= (state_d != ST_ACTIVE);
      other_periph_run <= awake;
      dead_time_timer_clk_run <= awake;
      rtc_counter_run <= awake ||
        (in_stby && keep_q[KEEP_RTC_BIT]);
      periodic_interrupt_timer_run <= 1'b1;
      main_clk_run <= awake ||
        (in_stby && keep_q[KEEP_MCLK_BIT]);
      configurable_logic_clk_run <= awake ||
        (in_stby && keep_q[KEEP_PERIPH_LSB]);
      wdt_run <= 1'b1;
      bod_run <= 1'b1;
      event_routing_run <= 1'b1;
      bod_osc_run <= (state_q != ST_SLEEP) ||
        bod_sampled_mode;
    end
  end

endmodule

/* hdl/smpg_pkg.sv */
// Purpose: shared constants and types of the sleep and power gating block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: byte address of a register is four times its index

package smpg_pkg;

  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_VREG = 6'h01;
  localparam logic [5:0] IDX_KEEP = 6'h02;
  localparam logic [5:0] IDX_STAT = 6'h03;

  // ==========================================================
  // field positions
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int MODE_W = 3;
  localparam int VREG_PSEL_LSB = 0;
  localparam int PSEL_W = 3;
  localparam int VREG_HOT_BIT = 4;
  localparam int KEEP_RTC_BIT = 0;
  localparam int KEEP_MCLK_BIT = 1;
  localparam int KEEP_PERIPH_LSB = 2;
  localparam int N_COND = 8;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB = 2;
  localparam int STAT_LOWCUR_BIT = 5;
  localparam int STAT_FULL_BIT = 6;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] VREG_RST = 8'h00;
  localparam logic [N_COND+1:0] KEEP_RST = '0;

  // ==========================================================
  // encodings
  localparam logic [MODE_W-1:0] MODE_IDLE = 3'h0;
  localparam logic [MODE_W-1:0] MODE_STANDBY = 3'h1;
  localparam logic [MODE_W-1:0] MODE_PDOWN = 3'h2;
  localparam logic [PSEL_W-1:0] PSEL_AUTO = 3'h0;
  localparam logic [PSEL_W-1:0] PSEL_FULL = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // timing
  localparam int WAKE_CYCLES = 6;

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} smpg_state_e;

endpackage

/* hdl/smpg_axil_slave.sv */
// Purpose: AXI4-Lite slave handshake, turns bus traffic into strobes
// Assumes: one write and one read outstanding at most
// Notes: address and data of a write are taken in either order

`timescale 1ns/100ps

module smpg_axil_slave
  import smpg_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write channels
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // read channels
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // register side
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  // ==========================================================
  // write path
  assign wr_en = !s_awready && !s_wready && !s_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end
    else if (ce)
    begin
      if (s_awvalid && s_awready)
      begin
        s_awready <= 1'b0;
        wr_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        s_wready <= 1'b0;
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
      end
      if (wr_en)
      begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read path
  assign rd_en = !s_arready && !s_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rresp <= RESP_OKAY;
      s_rdata <= 32'h0;
      rd_addr <= '0;
    end
    else if (ce)
    begin
      if (s_arvalid && s_arready)
      begin
        s_arready <= 1'b0;
        rd_addr <= s_araddr;
      end
      if (rd_en)
      begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_ok ? rd_data : 32'h0;
        s_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_rvalid && s_rready)
      begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

endmodule

/* hdl/smpg_wake_timer.sv */
// Purpose: wake-up delay, fixed cycle count overlapped with source start-up
// Assumes: ready inputs come from logic on the same clock
// Notes: done is a one-cycle pulse

`timescale 1ns/100ps

module smpg_wake_timer
  import smpg_pkg::*;
#(
  parameter int CYCLES = WAKE_CYCLES
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  input wire logic start,
  input wire logic need_osc,
  input wire logic need_reg,
  input wire logic osc_ready,
  input wire logic reg_ready,
  output logic done
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  logic need_osc_q;
  logic need_reg_q;
  logic ready;

  // start-up waits overlap the fixed count rather than add to it
  assign ready = (!need_osc_q || osc_ready) && (!need_reg_q || reg_ready);

  // ==========================================================
  // counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      need_osc_q <= 1'b0;
      need_reg_q <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start)
      begin
        busy_q <= 1'b1;
        cnt_q <= '0;
        need_osc_q <= need_osc;
        need_reg_q <= need_reg;
      end
      else if (busy_q)
      begin
        if (cnt_q != LAST)
          cnt_q <= cnt_q + 1'b1;
        else if (ready)
        begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

/* verification/smpg_top_monitor.sv */
// Purpose: assertion checker beside smpg_top
// Assumes: bound to smpg_top, sees its ports only
// Notes: sleep state is hidden, so outputs are tied to cpu_halt
`timescale 1ns/100ps
module smpg_monitor
#(
  parameter int NCOND = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // cpu and status
  input wire logic debug_break,
  input wire logic cpu_halt,
  input wire logic low_freq_internal_osc_only,
  input wire logic bod_sampled_mode,
  // regulator and gating
  input wire logic reg_low_current,
  input wire logic reg_full_perf,
  input wire logic leak_save,
  input wire logic [NCOND-1:0] cond_periph_run,
  input wire logic other_periph_run,
  input wire logic rtc_counter_run,
  input wire logic periodic_interrupt_timer_run,
  input wire logic main_clk_run,
  input wire logic configurable_logic_clk_run,
  input wire logic dead_time_timer_clk_run,
  input wire logic wdt_run,
  input wire logic bod_run,
  input wire logic event_routing_run,
  input wire logic bod_osc_run
);
  // ======
  // assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  guards_on_a: assert property (
    wdt_run && bod_run && event_routing_run)
    else $error("guard unit gated");
  timer_on_a: assert property (
    periodic_interrupt_timer_run) else $error("timer gated");
  dead_time_a: assert property (
    dead_time_timer_clk_run == other_periph_run)
    else $error("dead-time clock apart from peripherals");
  low_current_a: assert property (
    reg_low_current |-> !reg_full_perf && $past(cpu_halt)
    && $past(low_freq_internal_osc_only)) else $error("bad low current");
  full_perf_a: assert property (
    !reg_full_perf |-> $past(cpu_halt)) else $error("regulator low awake");
  idle_run_a: assert property (
    !other_periph_run |-> $past(cpu_halt)) else $error("gated awake");
  leak_gate_a: assert property (
    leak_save |-> !main_clk_run && !rtc_counter_run
    && cond_periph_run == '0) else $error("leak save while running");
  logic_clk_a: assert property (
    configurable_logic_clk_run == cond_periph_run[0])
    else $error("logic clock apart from logic");
  bod_osc_a: assert property (
    !bod_osc_run |-> $past(cpu_halt) && !$past(bod_sampled_mode))
    else $error("brown-out osc stopped");
  wake_len_a: assert property (
    $fell(cpu_halt) |-> $past(cpu_halt, 7)) else $error("wake too short");
  debug_wake_a: assert property (
    cpu_halt && debug_break |-> ##[1:40] !cpu_halt)
    else $error("no wake on debug break");
  cover property ($fell(cpu_halt));
  cover property (leak_save);
  cover property (reg_low_current && bod_osc_run);
endmodule

bind smpg_top smpg_monitor #(.NCOND(NCOND)) smpg_monitor_i (
  .aclk, .aresetn, .debug_break, .cpu_halt, .low_freq_internal_osc_only,
  .bod_sampled_mode, .reg_low_current, .reg_full_perf, .leak_save,
  .cond_periph_run, .other_periph_run, .rtc_counter_run,
  .periodic_interrupt_timer_run, .main_clk_run, .configurable_logic_clk_run,
  .dead_time_timer_clk_run, .wdt_run, .bod_run, .event_routing_run,
  .bod_osc_run);

/* verification/smpg_partner.sv */
// Purpose: main clock source and regulator start-up model
// Assumes: driven by the gating outputs of smpg_top
// Notes: ready drops one cycle after a source is gated off
`timescale 1ns/100ps
module smpg_partner
#(
  parameter int SU = 10
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requests
  input wire logic main_clk_run,
  input wire logic reg_low_current,
  // status
  output logic osc_ready,
  output logic reg_ready
);
  // ======
  // start-up counters, slower than the fixed wake count on purpose
  int osc_q;
  int reg_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !main_clk_run)
      osc_q <= 0;
    else if (osc_q < SU)
      osc_q <= osc_q + 1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || reg_low_current)
      reg_q <= 0;
    else if (reg_q < SU)
      reg_q <= reg_q + 1;
  end
  assign osc_ready = (osc_q >= SU);
  assign reg_ready = (reg_q >= SU);
endmodule

/* verification/smpg_top_tb.sv */
// Purpose: self-checking bench for smpg_top
// Assumes: AXI4-Lite master tasks, one access at a time
// Notes: sleep cases come from a table, wake sources pulse one cycle
`timescale 1ns/100ps
module smpg_top_tb
  import smpg_pkg::*;
;
  // ======
  // signals
  localparam int SU = 10;
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_VREG = {IDX_VREG, 2'b00};
  localparam logic [7:0] A_KEEP = {IDX_KEEP, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
  localparam logic [20:0] AWAKE = {8'hff, 10'h3ff, 3'b010};
  localparam logic [2:0] T_MODE [5] = '{0, 1, 1, 2, 2};
  localparam logic [2:0] T_PSEL [5] = '{0, 0, 1, 0, 0};
  localparam logic T_HOT [5] = '{0, 0, 0, 1, 0};
  localparam logic [9:0] T_KEEP [5] = '{0, 'h2a5, 'h15a, 'h3ff, 0};
  localparam logic T_OSC [5] = '{1, 1, 1, 0, 1};
  localparam logic T_BOD [5] = '{0, 1, 0, 1, 0};
  // wake sources: any, standby, pdown, debug, two-wire, logic
  localparam logic [5:0] T_WAKE [5] = '{1, 16, 32, 4, 8};
  localparam logic [5:0] T_NOWK [5] = '{0, 1, 1, 2, 1};
  logic aclk = 0;
  logic aresetn = 0;
  logic ce = 1;
  logic [7:0] s_awaddr = '0;
  logic [7:0] s_araddr = '0;
  logic [31:0] s_wdata = '0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
  logic s_rready = 0, sleep_instr = 0, osc1 = 0, bodsm = 0;
  logic [5:0] src = '0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cpu_halt;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic osc_ready, reg_ready, rlc, rfp, leak, other, rtc, periodic_interrupt_timer, mclk;
  logic cclk, dclk, wdt, bod, evr, bosc;
  logic [7:0] cond;
  wire logic [20:0] got = {cond, other, rtc, periodic_interrupt_timer, mclk, cclk, dclk, wdt,
    bod, evr, bosc, rlc, rfp, leak};
  int failures = 0;
  int compares = 0;
  always #4 aclk = ~aclk;

  smpg_top #(.ADDR_W(8), .NCOND(8)) smpg_top_i (
    .aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .sleep_instr, .debug_break(src[3]), .cpu_halt,
    .irq_any(src[0]), .irq_standby(src[1]), .irq_pdown(src[2]),
    .irq_two_wire_target(src[4]), .irq_configurable_logic(src[5]),
    .low_freq_internal_osc_only(osc1), .bod_sampled_mode(bodsm),
    .osc_ready, .reg_ready, .reg_low_current(rlc), .reg_full_perf(rfp),
    .leak_save(leak), .cond_periph_run(cond), .other_periph_run(other),
    .rtc_counter_run(rtc), .periodic_interrupt_timer_run(periodic_interrupt_timer),
    .main_clk_run(mclk), .configurable_logic_clk_run(cclk),
    .dead_time_timer_clk_run(dclk), .wdt_run(wdt), .bod_run(bod),
    .event_routing_run(evr), .bod_osc_run(bosc));
  smpg_partner #(.SU(SU)) smpg_partner_i (.aclk, .aresetn,
    .main_clk_run(mclk), .reg_low_current(rlc), .osc_ready, .reg_ready);

  // ======
  // tasks
  task automatic stop_test;
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 40 && s_bvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
    if (n == 40) failures++;
    if (n == 40) stop_test();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 40 && s_rvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    if (n == 40) failures++;
    if (n == 40) stop_test();
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp({30'h0, r}, {30'h0, RESP_OKAY});
    cmp(d, e);
  endtask
  task automatic slp;
    @(posedge aclk);
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  function automatic logic [20:0] expv(input int i);
    logic sb, pd, aw;
    logic [9:0] k;
    sb = T_MODE[i] == MODE_STANDBY;
    pd = T_MODE[i] == MODE_PDOWN;
    aw = T_MODE[i] == MODE_IDLE;
    k = T_KEEP[i];
    return {pd ? 8'h00 : sb ? k[9:2] : 8'hff, aw, !pd && (aw || k[0]),
      1'b1, !pd && (aw || k[1]), !pd && (aw || k[2]), aw, 3'b111,
      T_BOD[i], T_PSEL[i] == PSEL_AUTO && !aw && T_OSC[i],
      T_PSEL[i] == PSEL_FULL || aw, pd && T_HOT[i]};
  endfunction

  // ======
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [20:0] e;
    int i, n, lo;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp({cpu_halt, got}, {1'b0, AWAKE});
    chk(A_CTRL, 32'h0);
    chk(A_STAT, 32'h40);
    rd(8'h10, d, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    cmp(d, 32'h0);
    wr(8'h10, 32'hffffffff);
    cmp({30'h0, s_bresp}, {30'h0, RESP_SLVERR});
    wr(A_STAT, 32'hff);
    chk(A_STAT, 32'h40);
    wr(A_VREG, 32'hffffffff);
    chk(A_VREG, 32'h17);
    wr(A_KEEP, 32'hffffffff);
    chk(A_KEEP, 32'h3ff);
    // only lane 1 enabled: bits 9:8 clear, low byte kept
    s_wstrb <= 4'h2;
    wr(A_KEEP, 32'h0);
    chk(A_KEEP, 32'h0ff);
    s_wstrb <= 4'hf;
    wr(A_CTRL, 32'hffffffff);
    chk(A_CTRL, 32'h0f);
    slp();
    cmp(cpu_halt, 1'b0);
    wr(A_CTRL, 32'h2);
    slp();
    cmp(cpu_halt, 1'b0);
    for (i = 0; i < 5; i++)
    begin
      osc1 <= T_OSC[i];
      bodsm <= T_BOD[i];
      // two-wire and logic sources stay quiet while hot
      wr(A_VREG, {27'h0, T_HOT[i], 1'b0, T_PSEL[i]});
      wr(A_KEEP, {22'h0, T_KEEP[i]});
      wr(A_CTRL, {28'h0, T_MODE[i], 1'b1});
      slp();
      e = expv(i);
      cmp({cpu_halt, got}, {1'b1, e});
      chk(A_STAT, {25'h0, e[1], e[2], T_MODE[i], 2'b01});
      src <= T_NOWK[i];
      @(posedge aclk);
      src <= '0;
      repeat (3) @(posedge aclk);
      cmp(cpu_halt, 1'b1);
      src <= T_WAKE[i];
      @(posedge aclk);
      src <= '0;
      for (n = 1; n < 60 && cpu_halt !== 1'b0; n++)
        @(posedge aclk);
      if (n == 60) failures++;
      if (n == 60) stop_test();
      lo = (i == 0 || i == 2) ? WAKE_CYCLES : SU;
      cmp(n >= lo, 1'b1);
      repeat (2) @(posedge aclk);
      cmp({cpu_halt, got}, {1'b0, AWAKE});
    end
    // clock enable low must freeze the sleep entry
    ce <= 1'b0;
    slp();
    cmp(cpu_halt, 1'b0);
    ce <= 1'b1;
    slp();
    cmp(cpu_halt, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp({cpu_halt, got}, {1'b0, AWAKE});
    chk(A_CTRL, 32'h0);
    stop_test();
  end
endmodule
